// file: ldcc_call_ctrl.v
// Call control logic of a single channel loop detector
// Function
// RULE1: Noise filter disable bypasses filtering; changing it resets the detector.
// RULE2: Green compensation desensitises 0.05% over 15 s while green and calling.
// RULE3: Vehicle count runs to 65535 then wraps to zero.
// RULE4: Count display shows low three digits, alternating upper digits above 999.
// RULE5: Counter reset off-to-on clears count; it always reads off first.
// RULE6: Counting loop configuration is limited to 1 through 5.
// RULE7: Buzzer follows raw occupancy when audible option on.
// RULE8: Audible option turns off after 15 minutes or power loss.
// RULE9: Disconnect during green: extension expiry suppresses calls until green ends.
// RULE10: Disconnect type off: extension still applies, call held until disconnect.
// RULE11: Disconnect type on: no extension, call follows occupancy until disconnect.
// RULE12: Reset on power, filter change, sensitivity/frequency change, 3 s button.
// RULE13: Diagnostics survive button/filter resets; power reset clears them.
// RULE14: Phase green aborts delay and enables green controls.
// RULE15: Backlight on at any button, off 15 minutes after last press.
// RULE16: Detect LED lit on call, delay, extension running or loop fail.
// RULE17: Operational 2 s after reset; full sensitivity after 30 s.
// RULE18: Loop fault enters fail-safe with low or high message.
// RULE19: Fail-safe gives continuous call in presence and pulse modes.
// RULE20: Loop failure starts three-flash bursts each second until reset; the code stops them only on power or manual reset.
// RULE21: Loop fail memory counts failures; cleared by power or manual reset.
// RULE22: Three buttons held 5 s restore defaults; early release aborts.
// RULE23: Extension 0 to 25.5 s in 0.1 s; restarts on new entry.
// RULE24: Count increments per recognised vehicle, independent of call state.
`timescale 1ns/1ns
`default_nettype none
`include "ldcc_consts.vh"
module ldcc_call_ctrl #(
   parameter TICK_CYC = `LDCC_TICK_CYC,
   parameter DELAY_W = 8,
   parameter FAILMEM_W = 8
) (
   input wire core_clk,
   input wire resetn,
   input wire occupied,
   input wire vehicle_seen,
   input wire phase_green,
   input wire loop_low_fault,
   input wire loop_high_fault,
   input wire noise_filter_off,
   input wire sens_freq_change,
   input wire [DELAY_W-1:0] delay_s,
   input wire [7:0] ext_tenths,
   input wire pulse_mode,
   input wire ext_green_only,
   input wire green_comp_en,
   input wire count_disp_en,
   input wire counter_reset_set,
   input wire [2:0] loopcfg_req,
   input wire loopcfg_wr,
   input wire audible_set,
   input wire inductance_disp_set,
   input wire dll_disp_set,
   input wire disconnect_en,
   input wire disconnect_type,
   input wire menu_select_button,
   input wire up_button,
   input wire down_button,
   output reg call_out,
   output reg buzzer,
   output reg detect_led,
   output reg backlight,
   output reg filter_bypass,
   output reg comp_ramp_active,
   output reg [9:0] comp_ppm,
   output reg operational,
   output reg full_sensitivity,
   output reg loop_low_fault_msg,
   output reg loop_high_fault_msg,
   output reg [15:0] veh_count,
   output reg [11:0] disp_digits,
   output reg disp_upper,
   output reg counter_reset_view,
   output reg [2:0] loopcfg,
   output reg audible_on,
   output reg inductance_disp_on,
   output reg dll_disp_on,
   output reg [FAILMEM_W-1:0] fail_mem,
   output reg detector_reset,
   output reg factory_restore,
   output reg [2:0] restore_countdown
);
   // -------------------------------------------------
   // Timebase: 100 ms tick and 1 s tick
   // -------------------------------------------------
   localparam SEC_TICKS = `LDCC_SEC_TICKS;
   reg [23:0] pre_q;
   reg [3:0] tenth_q;
   wire tick = (pre_q == TICK_CYC - 1);
   wire sec = tick && (tenth_q == SEC_TICKS - 1);
   always @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         pre_q <= 24'h0;
         tenth_q <= 4'h0;
      end
      else
      begin
         pre_q <= tick ? 24'h0 : pre_q + 24'h1;
         if (tick)
            tenth_q <= sec ? 4'h0 : tenth_q + 4'h1;
      end
   end

   function [3:0] bcd_digit;
      input [15:0] v;
      input [15:0] div;
      reg [15:0] q;
      begin
         q = (v / div) % 16'd10;
         bcd_digit = q[3:0];
      end
   endfunction

   // -------------------------------------------------
   // Reset sources and button hold timers
   // -------------------------------------------------
   reg nf_q;
   reg [11:0] hold_q;
   reg all3_q;
   reg nf_ok_q;
   wire all3 = menu_select_button && up_button && down_button;
   wire any_btn = menu_select_button || up_button || down_button;
   // No change is seen before the first sample after power-up
   wire nf_change = nf_ok_q && (noise_filter_off != nf_q);
   wire [31:0] cd_full = `LDCC_RESTORE_S - hold_q / 12'd10;
   wire menu_select_button_rst = menu_select_button && !all3 && (hold_q == `LDCC_MENU_SELECT_BUTTON_HOLD_S * 10 - 1) && tick;
   wire restore_done = all3 && (hold_q == `LDCC_RESTORE_S * 10 - 1) && tick;
   wire soft_rst = nf_change || sens_freq_change || menu_select_button_rst || restore_done; // [RULE12]
   always @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         nf_q <= 1'b0;
         nf_ok_q <= 1'b0;
         all3_q <= 1'b0;
         hold_q <= 12'h0;
         detector_reset <= 1'b0;
         factory_restore <= 1'b0;
         restore_countdown <= 3'h0;
         filter_bypass <= 1'b0;
      end
      else
      begin
         nf_q <= noise_filter_off;
         nf_ok_q <= 1'b1;
         all3_q <= all3;
         filter_bypass <= noise_filter_off; // [RULE1]
         detector_reset <= soft_rst; // [RULE1]
         factory_restore <= restore_done; // [RULE22]
         // Restart on menu select release or a change of the three-button state, so a prior menu hold cannot shorten it
         if (!menu_select_button || all3 != all3_q)
            hold_q <= 12'h0; // [RULE22]
         else if (tick)
            hold_q <= hold_q + 12'h1;
         restore_countdown <= all3 ? cd_full[2:0] : 3'h0; // [RULE22]
      end
   end

   // -------------------------------------------------
   // Tuning, backlight and diagnostic options
   // -------------------------------------------------
   reg [5:0] run_q;
   reg [13:0] bl_q;
   reg [13:0] aud_q;
   localparam [13:0] BL_S = `LDCC_BACKLIGHT_S;
   localparam [13:0] AUD_S = `LDCC_AUDIO_TIMEOUT_S;
   always @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         run_q <= 6'h0;
         bl_q <= 14'h0;
         aud_q <= 14'h0;
         operational <= 1'b0;
         full_sensitivity <= 1'b0;
         backlight <= 1'b0;
         audible_on <= 1'b0; // [RULE8] [RULE13]
         inductance_disp_on <= 1'b0;
         dll_disp_on <= 1'b0;
         buzzer <= 1'b0;
      end
      else
      begin
         if (soft_rst)
            run_q <= 6'h0;
         else if (sec && run_q != 6'h3f)
            run_q <= run_q + 6'h1;
         operational <= !soft_rst && run_q >= `LDCC_TUNE_S; // [RULE17]
         full_sensitivity <= !soft_rst && run_q >= `LDCC_FULL_SENS_S; // [RULE17]
         if (any_btn)
            bl_q <= BL_S;
         else if (sec && bl_q != 14'h0)
            bl_q <= bl_q - 14'h1;
         backlight <= any_btn || bl_q != 14'h0; // [RULE15]
         // Soft resets leave diagnostic options untouched
         if (audible_set && !audible_on)
         begin
            audible_on <= 1'b1;
            aud_q <= AUD_S;
         end
         else if (sec && audible_on)
         begin
            aud_q <= aud_q - 14'h1;
            if (aud_q == 14'h1)
               audible_on <= 1'b0; // [RULE8]
         end
         if (inductance_disp_set)
            inductance_disp_on <= 1'b1; // [RULE13]
         if (dll_disp_set)
            dll_disp_on <= 1'b1;
         buzzer <= audible_on && occupied; // [RULE7]
      end
   end

   // -------------------------------------------------
   // Call path: delay, extension, disconnect, fail-safe
   // -------------------------------------------------
   reg occ_q;
   reg disc_q;
   reg fail_q;
   reg burst_q;
   reg [3:0] burst_ph_q;
   wire fault = loop_low_fault || loop_high_fault;
   wire occ_end = occ_q && !occupied;
   wire ext_ok = !(disconnect_en && disconnect_type) && (!ext_green_only || phase_green);
   wire ext_run;
   wire ext_exp;
   wire dly_run;
   wire disc_timing = disconnect_en && phase_green;
   ldcc_tick_timer #(.W(8)) u_ext (
      .core_clk(core_clk),
      .resetn(resetn),
      .clr(soft_rst || occupied), // [RULE23]
      .load(occ_end && (ext_ok || disc_timing)), // [RULE9] [RULE23]
      .load_val(ext_tenths),
      .tick(tick),
      .running(ext_run),
      .expired(ext_exp)
   );
   ldcc_tick_timer #(.W(DELAY_W + 4)) u_dly (
      .core_clk(core_clk),
      .resetn(resetn),
      .clr(soft_rst || phase_green || !occupied), // [RULE14]
      .load(occupied && !occ_q),
      .load_val({delay_s, 4'h0} - {4'h0, delay_s} - {4'h0, delay_s} - {4'h0, delay_s}
         - {4'h0, delay_s} - {4'h0, delay_s} - {4'h0, delay_s}),
      .tick(tick),
      .running(dly_run),
      .expired()
   );
   wire ext_hold = ext_run && !(disconnect_en && disconnect_type && phase_green); // [RULE11]
   wire dly_start = occupied && !occ_q && !phase_green && (delay_s != {DELAY_W{1'b0}});
   // Cover the load cycles: no call blip at a delayed entry, no drop at exit
   wire normal_call = (occupied && !dly_run && !dly_start)
      || ((ext_hold || (occ_end && ext_tenths != 8'h00)) && ext_ok); // [RULE10]
   always @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         occ_q <= 1'b0;
         disc_q <= 1'b0;
         fail_q <= 1'b0;
         burst_q <= 1'b0;
         burst_ph_q <= 4'h0;
         call_out <= 1'b0;
         detect_led <= 1'b0;
         loop_low_fault_msg <= 1'b0;
         loop_high_fault_msg <= 1'b0;
         fail_mem <= {FAILMEM_W{1'b0}}; // [RULE21]
      end
      else
      begin
         occ_q <= occupied;
         fail_q <= fault;
         if (!phase_green || soft_rst)
            disc_q <= 1'b0;
         else if (disconnect_en && ext_exp && !occupied)
            disc_q <= 1'b1; // [RULE9]
         loop_low_fault_msg <= loop_low_fault; // [RULE18]
         loop_high_fault_msg <= loop_high_fault && !loop_low_fault; // [RULE18]
         if (fault)
            call_out <= 1'b1; // [RULE19]
         else if (!operational || disc_q)
            call_out <= 1'b0;
         else
            call_out <= normal_call;
         // A failure in the clearing cycle is still counted and still flashed
         if (menu_select_button_rst || restore_done)
            fail_mem <= {{(FAILMEM_W-1){1'b0}}, fault && !fail_q}; // [RULE21]
         else if (fault && !fail_q)
            fail_mem <= fail_mem + {{(FAILMEM_W-1){1'b0}}, 1'b1}; // [RULE21]
         if (fault)
            burst_q <= 1'b1; // [RULE20]
         else if (menu_select_button_rst || restore_done)
            burst_q <= 1'b0;
         if (sec || !burst_q)
            burst_ph_q <= 4'h0;
         else if (tick)
            burst_ph_q <= burst_ph_q + 4'h1;
         // Flash on even tenths for the first three pairs of each second
         detect_led <= call_out || dly_run || ext_run || fault
            || (burst_q && !burst_ph_q[0] && burst_ph_q < 2 * `LDCC_BURST_FLASHES); // [RULE16] [RULE20]
      end
   end

   // -------------------------------------------------
   // Compensation ramp during green
   // -------------------------------------------------
   reg [7:0] ramp_q;
   localparam [7:0] RAMP_END = `LDCC_COMP_RAMP_S * 10;
   wire [31:0] ppm_full = (`LDCC_COMP_PPM * ramp_q) / (`LDCC_COMP_RAMP_S * 10);
   always @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         ramp_q <= 8'h0;
         comp_ramp_active <= 1'b0;
         comp_ppm <= 10'h0;
      end
      else
      begin
         if (!(green_comp_en && phase_green && call_out) || soft_rst)
            ramp_q <= 8'h0; // [RULE2]
         else if (tick && ramp_q != RAMP_END)
            ramp_q <= ramp_q + 8'h1;
         comp_ramp_active <= green_comp_en && phase_green && call_out; // [RULE2] [RULE14]
         comp_ppm <= ppm_full[9:0]; // [RULE2]
      end
   end

   // -------------------------------------------------
   // Vehicle counting and display
   // -------------------------------------------------
   reg crs_q;
   wire [15:0] hi_part = veh_count / 16'd1000;
   always @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         crs_q <= 1'b0;
         veh_count <= 16'h0;
         counter_reset_view <= 1'b0;
         loopcfg <= `LDCC_LOOPCFG_DEF;
         disp_digits <= 12'h0;
         disp_upper <= 1'b0;
      end
      else
      begin
         crs_q <= counter_reset_set;
         counter_reset_view <= 1'b0; // [RULE5]
         if (restore_done)
            loopcfg <= `LDCC_LOOPCFG_DEF;
         else if (loopcfg_wr && loopcfg_req >= `LDCC_LOOPCFG_MIN && loopcfg_req <= `LDCC_LOOPCFG_MAX)
            loopcfg <= loopcfg_req; // [RULE6]
         if (counter_reset_set && !crs_q)
            veh_count <= 16'h0; // [RULE5]
         else if (vehicle_seen)
            veh_count <= veh_count + 16'h1; // [RULE3] [RULE24]
         if (!count_disp_en || veh_count <= `LDCC_DISP_SPLIT)
            disp_upper <= 1'b0; // [RULE4]
         else if (sec)
            disp_upper <= !disp_upper; // [RULE4]
         if (!count_disp_en)
            disp_digits <= 12'h0;
         else if (disp_upper)
            disp_digits <= {4'h0, bcd_digit(hi_part, 16'd10), bcd_digit(hi_part, 16'd1)};
         else
            disp_digits <= {bcd_digit(veh_count, 16'd100), bcd_digit(veh_count, 16'd10),
               bcd_digit(veh_count, 16'd1)};
      end
   end
endmodule
`default_nettype wire

// file: ldcc_call_ctrl_chk.sv
// Concurrent assertions on the call control block ports
`timescale 1ns/1ns
`default_nettype none
module ldcc_call_ctrl_chk (
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic occupied,
   input wire logic vehicle_seen,
   input wire logic loop_low_fault,
   input wire logic loop_high_fault,
   input wire logic noise_filter_off,
   input wire logic counter_reset_set,
   input wire logic [2:0] loopcfg_req,
   input wire logic loopcfg_wr,
   input wire logic call_out,
   input wire logic buzzer,
   input wire logic detect_led,
   input wire logic audible_on,
   input wire logic loop_low_fault_msg,
   input wire logic loop_high_fault_msg,
   input wire logic [15:0] veh_count,
   input wire logic counter_reset_view,
   input wire logic [2:0] loopcfg,
   input wire logic detector_reset,
   input wire logic factory_restore
);
   // ----------------------------------------
   // Properties
   // ----------------------------------------
   default clocking @(posedge core_clk); endclocking
   default disable iff (!resetn);
   sequence occ_heard_s;
      audible_on && occupied ##1 audible_on;
   endsequence
   sequence plain_count_s;
      vehicle_seen && !counter_reset_set;
   endsequence
   buzz_follow_a: assert property (occ_heard_s |-> buzzer)
      else $error("buzzer silent while zone occupied");
   count_inc_a: assert property ((plain_count_s and (veh_count != 16'hffff)) |=>
      veh_count == $past(veh_count) + 16'h0001) else $error("vehicle not counted");
   count_wrap_a: assert property ((plain_count_s and (veh_count == 16'hffff)) |=>
      veh_count == 16'h0000) else $error("count did not wrap to zero");
   cnt_clear_a: assert property ($rose(counter_reset_set) |=> veh_count == 16'h0000)
      else $error("counter reset did not clear count");
   view_off_a: assert property (counter_reset_view == 1'b0)
      else $error("counter reset view not off");
   cfg_range_a: assert property (loopcfg >= 3'h1 && loopcfg <= 3'h5)
      else $error("loop configuration out of range");
   cfg_refuse_a: assert property (loopcfg_wr && (loopcfg_req == 3'h0 || loopcfg_req > 3'h5)
      |=> $stable(loopcfg)) else $error("bad loop configuration taken");
   low_fault_a: assert property (loop_low_fault |=> call_out && loop_low_fault_msg)
      else $error("low loop fault without fail-safe call");
   high_fault_a: assert property (loop_high_fault |=> call_out && loop_high_fault_msg)
      else $error("high loop fault without fail-safe call");
   nf_reset_a: assert property ($changed(noise_filter_off) |=> detector_reset)
      else $error("filter option change did not reset");
   led_call_a: assert property (call_out |-> ##[0:1] detect_led)
      else $error("detect indicator dark during call");
   restore_pulse_a: assert property (factory_restore |=> !factory_restore)
      else $error("restore pulse longer than one cycle");
endmodule
bind ldcc_call_ctrl ldcc_call_ctrl_chk i_chk (.core_clk, .resetn, .occupied, .vehicle_seen,
   .loop_low_fault, .loop_high_fault, .noise_filter_off, .counter_reset_set, .loopcfg_req,
   .loopcfg_wr, .call_out, .buzzer, .detect_led, .audible_on, .loop_low_fault_msg,
   .loop_high_fault_msg, .veh_count, .counter_reset_view, .loopcfg, .detector_reset,
   .factory_restore);
`default_nettype wire

// file: ldcc_call_ctrl_tb.sv
// Self-checking testbench for the call control block
`timescale 1ns/1ns
`default_nettype none
module ldcc_call_ctrl_tb;
   logic core_clk, resetn, occupied, vehicle_seen, phase_green, loop_low_fault, loop_high_fault;
   logic noise_filter_off, sens_freq_change, green_comp_en, count_disp_en, counter_reset_set;
   logic loopcfg_wr, audible_set, disconnect_en, disconnect_type, green_req, menu_select_button;
   logic up_button, down_button, call_out, buzzer, detect_led, backlight, filter_bypass;
   logic comp_ramp_active, operational, loop_low_fault_msg, loop_high_fault_msg, disp_upper;
   logic counter_reset_view, audible_on, detector_reset, factory_restore, r, f, hi, lo;
   logic inductance_disp_set, inductance_disp_on, full_sensitivity;
   logic [2:0] loopcfg_req, loopcfg;
   logic [7:0] ext_tenths, fail_mem, delay_s;
   logic [11:0] disp_digits;
   logic [15:0] veh_count;
   int miscompares, n_checks, i, k;
   // ----------------------------------------
   // Design, controller model and clock
   // ----------------------------------------
   ldcc_call_ctrl #(.TICK_CYC(10)) i_ldcc_call_ctrl (.core_clk, .resetn, .occupied,
      .vehicle_seen, .phase_green, .loop_low_fault, .loop_high_fault, .noise_filter_off,
      .sens_freq_change, .delay_s, .ext_tenths, .pulse_mode(1'b0),
      .ext_green_only(1'b0), .green_comp_en, .count_disp_en, .counter_reset_set,
      .loopcfg_req, .loopcfg_wr, .audible_set, .inductance_disp_set,
      .dll_disp_set(1'b0), .disconnect_en, .disconnect_type, .menu_select_button,
      .up_button, .down_button, .call_out, .buzzer, .detect_led, .backlight, .filter_bypass,
      .comp_ramp_active, .comp_ppm(), .operational, .full_sensitivity, .loop_low_fault_msg,
      .loop_high_fault_msg, .veh_count, .disp_digits, .disp_upper, .counter_reset_view,
      .loopcfg, .audible_on, .inductance_disp_on, .dll_disp_on(), .fail_mem,
      .detector_reset, .factory_restore, .restore_countdown());
   ldcc_green_ctrl_model i_ldcc_green_ctrl_model (.core_clk, .green_req, .phase_green);
   initial core_clk = 1'b0;
   always #50 core_clk = ~core_clk;
   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks = n_checks + 1;
      if (got !== exp)
      begin
         miscompares = miscompares + 1;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task cyc(input int n);
      repeat (n) @(negedge core_clk);
   endtask
   // Holds inputs, noting soft reset and restore pulses on the way
   task watch(input int n);
      r = 1'b0;
      f = 1'b0;
      repeat (n)
      begin
         @(negedge core_clk);
         r = r | detector_reset;
         f = f | factory_restore;
      end
   endtask
   // Any one second window holds exactly three flash rises while bursting
   task rises(output int n);
      n = 0;
      lo = detect_led;
      repeat (100)
      begin
         @(negedge core_clk);
         if (detect_led === 1'b1 && lo === 1'b0)
            n = n + 1;
         lo = detect_led;
      end
   endtask
   task wcfg(input logic [2:0] q, input logic [2:0] e);
      loopcfg_req = q;
      loopcfg_wr = 1'b1;
      cyc(1);
      loopcfg_wr = 1'b0;
      cyc(1);
      chk(loopcfg, e);
   endtask
   task tally_and_finish;
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   initial
   begin
      #(100 * 90000);
      miscompares = miscompares + 1;
      tally_and_finish;
   end
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   initial
   begin
      {occupied, vehicle_seen, loop_low_fault, loop_high_fault, noise_filter_off} = 5'h00;
      {sens_freq_change, green_comp_en, count_disp_en, counter_reset_set, loopcfg_wr} = 5'h00;
      {audible_set, inductance_disp_set, disconnect_en, disconnect_type, green_req} = 5'h00;
      {menu_select_button, up_button, down_button, loopcfg_req, ext_tenths, delay_s} = 22'h0;
      miscompares = 0;
      n_checks = 0;
      resetn = 1'b0;
      cyc(3);
      resetn = 1'b1;
      cyc(1);
      chk(loopcfg, 3'h4);
      cyc(150);
      chk({operational, full_sensitivity}, 2'b00);
      cyc(60);
      chk({operational, full_sensitivity}, 2'b10);
      {audible_set, inductance_disp_set} = 2'b11;
      cyc(1);
      {audible_set, inductance_disp_set} = 2'b00;
      occupied = 1'b1;
      cyc(2);
      chk({buzzer, call_out, detect_led}, 3'h7);
      occupied = 1'b0;
      cyc(2);
      chk(buzzer, 1'b0);
      for (k = 0; k < 2; k++)
      begin
         {loop_low_fault, loop_high_fault} = k ? 2'b01 : 2'b10;
         cyc(2);
         chk({loop_low_fault_msg, loop_high_fault_msg}, k ? 2'b01 : 2'b10);
         chk(call_out, 1'b1);
         chk(fail_mem, k + 1);
         {loop_low_fault, loop_high_fault} = 2'b00;
         cyc(40);
         chk({loop_low_fault_msg, loop_high_fault_msg}, 2'b00);
      end
      rises(i);
      chk(i, 3);
      for (k = 0; k < 3; k++)
      begin
         noise_filter_off = (k == 0);
         sens_freq_change = (k == 1);
         menu_select_button = (k == 2);
         watch(k == 2 ? 320 : 1);
         {sens_freq_change, menu_select_button} = 2'b00;
         chk(r, 1'b1);
         chk({audible_on, inductance_disp_on}, 2'b11);
         cyc(210);
         chk(filter_bypass, k == 0);
      end
      chk(backlight, 1'b1);
      chk(fail_mem, 8'h00);
      rises(i);
      chk(i, 0);
      count_disp_en = 1'b1;
      vehicle_seen = 1'b1;
      cyc(5);
      vehicle_seen = 1'b0;
      cyc(2);
      chk({disp_upper, disp_digits, veh_count}, {1'b0, 12'h005, 16'h0005});
      counter_reset_set = 1'b1;
      cyc(2);
      chk({counter_reset_view, veh_count}, 17'h00000);
      counter_reset_set = 1'b0;
      vehicle_seen = 1'b1;
      cyc(1234);
      vehicle_seen = 1'b0;
      {hi, lo} = 2'b00;
      repeat (400)
      begin
         @(negedge core_clk);
         hi = hi | (disp_upper === 1'b1 && disp_digits[7:0] === 8'h01);
         lo = lo | (disp_upper === 1'b0 && disp_digits === 12'h234);
      end
      chk({hi, lo}, 2'b11);
      vehicle_seen = 1'b1;
      cyc(65535 - 1234);
      vehicle_seen = 1'b0;
      chk(veh_count, 16'hffff);
      vehicle_seen = 1'b1;
      cyc(1);
      vehicle_seen = 1'b0;
      chk(veh_count, 16'h0000);
      chk(full_sensitivity, 1'b1);
      wcfg(3'h5, 3'h5);
      wcfg(3'h6, 3'h5);
      wcfg(3'h0, 3'h5);
      wcfg(3'h1, 3'h1);
      wcfg(3'h3, 3'h3);
      {ext_tenths, disconnect_en, green_comp_en} = {8'h02, 2'b11};
      delay_s = 8'h01;
      for (k = 0; k < 2; k++)
      begin
         disconnect_type = k[0];
         green_req = 1'b1;
         cyc(3);
         occupied = 1'b1;
         cyc(3);
         chk({call_out, comp_ramp_active}, 2'b11);
         occupied = 1'b0;
         cyc(5);
         chk(call_out, k == 0);
         cyc(40);
         occupied = 1'b1;
         cyc(3);
         chk(call_out, 1'b0);
         green_req = 1'b0;
         cyc(4);
         chk(call_out, 1'b1);
         occupied = 1'b0;
         cyc(40);
      end
      occupied = 1'b1;
      cyc(3);
      chk({call_out, detect_led}, 2'b01);
      cyc(110);
      chk(call_out, 1'b1);
      occupied = 1'b0;
      cyc(2);
      {menu_select_button, up_button, down_button} = 3'b111;
      watch(200);
      {menu_select_button, up_button, down_button} = 3'b000;
      chk(f, 1'b0);
      cyc(2);
      {menu_select_button, up_button, down_button} = 3'b111;
      watch(600);
      {menu_select_button, up_button, down_button} = 3'b000;
      chk({f, r}, 2'b11);
      cyc(2);
      chk(loopcfg, 3'h4);
      resetn = 1'b0;
      cyc(1);
      resetn = 1'b1;
      cyc(2);
      chk({audible_on, inductance_disp_on, operational}, 3'h0);
      tally_and_finish;
   end
endmodule
`default_nettype wire

// file: ldcc_consts.vh
// Constants for the loop detector call control block
`ifndef LDCC_CONSTS_VH
`define LDCC_CONSTS_VH
`define LDCC_CLK_HZ 10000000
`define LDCC_TICK_MS 100
`define LDCC_TICK_CYC (`LDCC_CLK_HZ / 1000 * `LDCC_TICK_MS)
`define LDCC_SEC_TICKS 10
`define LDCC_AUDIO_TIMEOUT_S 900
`define LDCC_BACKLIGHT_S 900
`define LDCC_MENU_SELECT_BUTTON_HOLD_S 3
`define LDCC_RESTORE_S 5
`define LDCC_TUNE_S 2
`define LDCC_FULL_SENS_S 30
`define LDCC_COMP_RAMP_S 15
`define LDCC_COMP_PPM 500
`define LDCC_COUNT_MAX 16'hffff
`define LDCC_LOOPCFG_MIN 3'h1
`define LDCC_LOOPCFG_MAX 3'h5
`define LDCC_LOOPCFG_DEF 3'h4
`define LDCC_BURST_FLASHES 3
`define LDCC_DISP_SPLIT 16'd999
`endif

// file: ldcc_green_ctrl_model.sv
// Behavioural traffic controller driving the phase green input
`timescale 1ns/1ns
`default_nettype none
module ldcc_green_ctrl_model (
   input wire logic core_clk,
   input wire logic green_req,
   output logic phase_green
);
   logic req_q;
   always @(posedge core_clk)
      req_q <= green_req;
   // Moves one cycle after the request, never on the sampling edge
   always @(negedge core_clk)
      phase_green <= req_q;
endmodule
`default_nettype wire

// file: ldcc_tick_timer.v
// Down counter clocked by a tick enable, with load and expiry pulse
`timescale 1ns/1ns
`default_nettype none
module ldcc_tick_timer #(
   parameter W = 16
) (
   input wire core_clk,
   input wire resetn,
   input wire clr,
   input wire load,
   input wire [W-1:0] load_val,
   input wire tick,
   output wire running,
   output reg expired
);
   reg [W-1:0] cnt_q;
   assign running = (cnt_q != {W{1'b0}});
   always @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         cnt_q <= {W{1'b0}};
         expired <= 1'b0;
      end
      else
      begin
         expired <= 1'b0;
         if (clr)
            cnt_q <= {W{1'b0}};
         else if (load)
            cnt_q <= load_val;
         else if (tick && running)
         begin
            cnt_q <= cnt_q - {{(W-1){1'b0}}, 1'b1};
            if (cnt_q == {{(W-1){1'b0}}, 1'b1})
               expired <= 1'b1;
         end
      end
   end
endmodule
`default_nettype wire
